// ---- core/bdc_bus_watch.sv ----
`include "bdc_defines.svh"
`default_nettype none
module bdc_bus_watch (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       den_act,
  input  wire logic [4:0] timeout,
  input  wire logic       rdy_en,
  input  wire logic       flt_en,
  input  wire logic       flt_level,
  input  wire logic       rd_clear,
  output logic            wd_ready,
  output logic            fault_n
);
  logic [4:0] cnt_r, cnt_nxt;
  logic       fired_r, fired_nxt, fire;
  logic [1:0] pulse_r, pulse_nxt;
  logic       lvl_r, lvl_nxt, rdy_nxt, fault_n_nxt;

  // Fires once per data phase that outlives the timeout; restarts when it ends
  always_comb begin
    fire = 1'b0;
    cnt_nxt = cnt_r;
    fired_nxt = fired_r;
    if (!den_act) begin
      cnt_nxt = 5'h00;
      fired_nxt = 1'b0;
    end else if (!fired_r) begin
      if (cnt_r == timeout) begin
        fire = 1'b1;
        fired_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    rdy_nxt = fire && rdy_en;
    pulse_nxt = (pulse_r != 2'h0) ? pulse_r - 2'h1 : 2'h0;
    if (fire && flt_en && !flt_level) begin
      pulse_nxt = `BDC_PULSE_CLKS;
    end
    // A new timeout wins over a clearing read in the same cycle
    lvl_nxt = (lvl_r && !rd_clear) || (fire && flt_en && flt_level);
    fault_n_nxt = !(lvl_nxt || pulse_nxt != 2'h0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r    <= 5'h00;
      fired_r  <= 1'b0;
      pulse_r  <= 2'h0;
      lvl_r    <= 1'b0;
      wd_ready <= 1'b0;
      fault_n  <= 1'b1;
    end else begin
      cnt_r    <= cnt_nxt;
      fired_r  <= fired_nxt;
      pulse_r  <= pulse_nxt;
      lvl_r    <= lvl_nxt;
      wd_ready <= rdy_nxt;
      fault_n  <= fault_n_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- core/bdc_timer.sv ----
`include "bdc_defines.svh"
`default_nettype none
module bdc_timer (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [23:0]           reload,
  input  wire bdc_pkg::bdc_tmr_mode_t mode,
  input  wire logic                  ack,
  output logic                       irq_n
);
  logic [23:0] cnt_r, cnt_nxt;
  logic [1:0]  pulse_r, pulse_nxt;
  logic        lvl_r, lvl_nxt, irq_n_nxt, tc;

  // Down counter; held at the reload value while off so enabling starts a full period
  always_comb begin
    tc = 1'b0;
    cnt_nxt = cnt_r - 24'h00_0001;
    if (mode == bdc_pkg::BDC_TMR_OFF) begin
      cnt_nxt = reload;
    end else if (cnt_r == 24'h00_0000) begin
      tc = 1'b1;
      cnt_nxt = reload;
    end
    pulse_nxt = (pulse_r != 2'h0) ? pulse_r - 2'h1 : 2'h0;
    if (tc && mode == bdc_pkg::BDC_TMR_EDGE) begin
      pulse_nxt = `BDC_PULSE_CLKS;
    end
    // Terminal count wins over an acknowledge in the same cycle
    lvl_nxt = lvl_r && !ack && mode == bdc_pkg::BDC_TMR_LEVEL;
    if (tc && mode == bdc_pkg::BDC_TMR_LEVEL) begin
      lvl_nxt = 1'b1;
    end
    irq_n_nxt = !(lvl_nxt || pulse_nxt != 2'h0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r   <= 24'h00_0000;
      pulse_r <= 2'h0;
      lvl_r   <= 1'b0;
      irq_n   <= 1'b1;
    end else begin
      cnt_r   <= cnt_nxt;
      pulse_r <= pulse_nxt;
      lvl_r   <= lvl_nxt;
      irq_n   <= irq_n_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- core/bdc_top.sv ----
// Overview of operation
// - Respond only inside the programmed block, aligned to the block size.
// - Bit 20 clear gives three-clock RAS, set gives four clocks.
// - Interleaved bursts wait 2-0-0-0, or 3-0-1-0 with cycle extend.
// - Cycle extend adds one clock to RAS precharge.
// - Bit 19 set: request burst stop when a burst write starts.
// - Bit 18 set holds row address longer before switching to column.
// - Interleave bit one drives leaf A only; zero interleaves two leaves.
// - Non-interleaved bursts wait 2-1-1-1, or 3-2-2-2 with extend.
// - Buffer mode selects meaning of the two buffer control outputs.
// - Modes two and three output the leaf selected next clock.
// - Write latch outputs always latch write data; timing varies with mode.
// - Size code selects 2, 8, 32 or 128 MB, x1 or x4.
// - x4 codes address up to four banks sequentially within the block.
// - Refresh rate is clock divided by sixteen times value plus one.
// - Refresh waits for bursts; own accesses wait for refresh to end.
// - 24-bit timer reloads at terminal count, off after reset.
// - Edge mode drives a two-clock low timer interrupt pulse.
// - Level mode holds interrupt low until acknowledge code is written.
// - Bit 61 holds bus error until register 7 read, else pulse.
// - Byte 0 writes with control bits set keep the other fields.
// - Control codes steer page cache, timer acknowledge and timer mode.
`include "bdc_defines.svh"
`default_nettype none
module bdc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [29:0] proc_addr,
  input  wire logic        proc_ads_n,
  input  wire logic        proc_blast_n,
  input  wire logic        proc_w_r,
  input  wire logic [3:0]  proc_be_n,
  input  wire logic        proc_d_c,
  input  wire logic        proc_sup_n,
  input  wire logic        data_phase_active_in_n,
  input  wire logic [2:0]  chip_id,
  output logic             ready_n,
  output logic             burst_stop_request_n,
  output logic             bus_fault_out_n,
  output logic             timer_irq_n,
  output logic             refresh_n,
  output logic [11:0]      dram_addr_a,
  output logic [11:0]      dram_addr_b,
  output logic [3:0]       ras_a_n,
  output logic [3:0]       ras_b_n,
  output logic [3:0]       cas_a_n,
  output logic [3:0]       cas_b_n,
  output logic             mwe_a_n,
  output logic             mwe_b_n,
  output logic             leaf_a_output_drive_n,
  output logic             leaf_b_output_drive_n,
  output logic             leaf_a_write_latch_n,
  output logic             leaf_b_write_latch_n,
  output logic             open_row_cache_inst,
  output logic             open_row_cache_data
);
  // Mask of the block address bits that take part in the compare
  function automatic logic [10:0] blk_mask(input logic [1:0] n);
    blk_mask = `BDC_BLOCK_ONES << {n, 1'b0};
  endfunction

  // Wait states before the ready of a given burst beat
  function automatic logic [1:0] beat_wait(input logic [1:0] beat, input logic ilv,
                                           input logic ext);
    if (beat == 2'h0) begin
      beat_wait = `BDC_WAIT_FIRST + {1'b0, ext};
    end else if (ilv) begin
      beat_wait = (ext && beat == 2'h2) ? `BDC_WAIT_ILV_EXT : 2'h0;
    end else begin
      beat_wait = `BDC_WAIT_NIL + {1'b0, ext};
    end
  endfunction

  // Word address of a beat, wrapping inside the aligned four-word burst
  function automatic logic [29:0] beat_word(input logic [29:0] a, input logic [1:0] beat);
    beat_word = {a[29:2], a[1:0] + beat};
  endfunction

  // Two flops on every pin; the first stage feeds only the second
  logic [42:0] s1_r, s2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= {43{1'b1}};
      s2_r <= {43{1'b1}};
    end else begin
      s1_r <= {proc_addr, proc_ads_n, proc_blast_n, proc_w_r, proc_be_n, proc_d_c,
               proc_sup_n, data_phase_active_in_n, chip_id};
      s2_r <= s1_r;
    end
  end
  logic [29:0] s_addr;
  logic [3:0]  s_be_n;
  logic [2:0]  s_id;
  logic        s_ads_n, s_blast_n, s_w_r, s_d_c, s_sup_n, s_den_n;
  assign {s_addr, s_ads_n, s_blast_n, s_w_r, s_be_n, s_d_c, s_sup_n, s_den_n, s_id} = s2_r;

  // Configuration and request state
  logic [63:0] cfg_r, cfg_nxt;
  logic        conf_r, conf_nxt, ic_r, ic_nxt, dc_r, dc_nxt;
  bdc_pkg::bdc_tmr_mode_t tmr_r, tmr_nxt;
  bdc_pkg::bdc_state_t    state_r, state_nxt;
  logic [29:0] req_addr_r, req_addr_nxt;
  logic [3:0]  req_be_n_r, req_be_n_nxt;
  logic        req_wr_r, req_wr_nxt, req_burst_r, req_burst_nxt, req_cfg_r, req_cfg_nxt;
  logic        pend_r, pend_nxt, ref_pend_r, ref_pend_nxt;
  logic [1:0]  beat_r, beat_nxt, wcnt_r, wcnt_nxt;
  logic [3:0]  pre_r, pre_nxt;
  logic [5:0]  rcnt_r, rcnt_nxt;
  logic [11:0] ref_row_r, ref_row_nxt;
  logic        tmr_ack, rd_watch, rdy, stop, take, take_ref, last, wd_ready;
  logic [7:0]  wval;

  logic        ilv, ext, cfg_hit, mem_hit;
  logic [2:0]  size;
  assign size = cfg_r[`BDC_F_SIZE];
  assign ilv  = !cfg_r[`BDC_B_ILV_DIS];
  assign ext  = cfg_r[`BDC_B_CYC_EXT];
  assign cfg_hit = s_addr[`BDC_A_SPACE] == `BDC_CFG_SPACE && s_addr[`BDC_A_ID] == s_id
                   && !s_sup_n;
  // Low block bits are ignored, which forces alignment to the block size
  assign mem_hit = conf_r && ((s_addr[`BDC_A_BLOCK] ^ cfg_r[`BDC_F_BLOCK])
                   & blk_mask(size[1:0])) == 11'h000;

  // Configuration writes and the operation control codes
  always_comb begin
    cfg_nxt = cfg_r;
    conf_nxt = conf_r;
    ic_nxt = ic_r;
    dc_nxt = dc_r;
    tmr_nxt = tmr_r;
    tmr_ack = 1'b0;
    rd_watch = 1'b0;
    wval = req_addr_r[`BDC_A_DATA];
    if (state_r == bdc_pkg::BDC_CFG && !req_wr_r) begin
      rd_watch = req_addr_r[`BDC_A_BYTE] == `BDC_BYTE_WATCH;
    end else if (state_r == bdc_pkg::BDC_CFG && req_addr_r[`BDC_A_BYTE] != `BDC_BYTE_OPCTL) begin
      cfg_nxt[{req_addr_r[`BDC_A_BYTE], 3'h0} +: 8] = wval;
      conf_nxt = 1'b1;
    end else if (state_r == bdc_pkg::BDC_CFG) begin
      case (wval[`BDC_F_OPCTL])
        `BDC_OP_NONE: begin
          cfg_nxt[`BDC_F_RSVD]   = wval[`BDC_F_RSVD];
          cfg_nxt[`BDC_F_REF_LO] = wval[`BDC_F_REF_LO];
        end
        `BDC_OP_IC_DIS:   ic_nxt = 1'b0;
        `BDC_OP_IC_EN:    ic_nxt = 1'b1;
        `BDC_OP_DC_DIS:   dc_nxt = 1'b0;
        `BDC_OP_DC_EN:    dc_nxt = 1'b1;
        `BDC_OP_TMR_ACK:  tmr_ack = 1'b1;
        `BDC_OP_TMR_LVL:  tmr_nxt = bdc_pkg::BDC_TMR_LEVEL;
        `BDC_OP_TMR_OFF:  tmr_nxt = bdc_pkg::BDC_TMR_OFF;
        `BDC_OP_TMR_EDGE: tmr_nxt = bdc_pkg::BDC_TMR_EDGE;
        default: begin
        end
      endcase
    end
  end

  // Request capture; refresh pacing with prescale by sixteen
  always_comb begin
    req_addr_nxt = req_addr_r;
    req_be_n_nxt = req_be_n_r;
    req_wr_nxt = req_wr_r;
    req_burst_nxt = req_burst_r;
    req_cfg_nxt = req_cfg_r;
    if (!s_ads_n && (cfg_hit || mem_hit)) begin
      req_addr_nxt = s_addr;
      req_be_n_nxt = s_be_n;
      req_wr_nxt = s_w_r;
      req_burst_nxt = s_blast_n;
      req_cfg_nxt = cfg_hit;
    end
    // A new request wins over the take in the same cycle
    pend_nxt = (pend_r && !take) || (!s_ads_n && (cfg_hit || mem_hit));
    pre_nxt = pre_r + 4'h1;
    rcnt_nxt = rcnt_r;
    ref_pend_nxt = ref_pend_r && !take_ref;
    if (pre_r == `BDC_REF_PRE_LAST) begin
      if (rcnt_r == {cfg_r[`BDC_F_REF_HI], cfg_r[`BDC_F_REF_LO]}) begin
        rcnt_nxt = 6'h00;
        ref_pend_nxt = conf_r;
      end else begin
        rcnt_nxt = rcnt_r + 6'h01;
      end
    end
  end

  // Access sequencer: RAS, data beats, precharge, refresh
  always_comb begin
    state_nxt = state_r;
    beat_nxt = beat_r;
    wcnt_nxt = wcnt_r + 2'h1;
    ref_row_nxt = ref_row_r;
    rdy = 1'b0;
    stop = 1'b0;
    last = 1'b0;
    take = 1'b0;
    take_ref = 1'b0;
    unique case (state_r)
      bdc_pkg::BDC_IDLE: begin
        wcnt_nxt = 2'h0;
        beat_nxt = 2'h0;
        if (ref_pend_r) begin
          take_ref = 1'b1;
          state_nxt = bdc_pkg::BDC_REF_NOTE;
        end else if (pend_r) begin
          take = 1'b1;
          state_nxt = req_cfg_r ? bdc_pkg::BDC_CFG : bdc_pkg::BDC_ACC;
        end
      end
      bdc_pkg::BDC_CFG: begin
        rdy = 1'b1;
        state_nxt = bdc_pkg::BDC_IDLE;
      end
      bdc_pkg::BDC_ACC: begin
        if (wcnt_r == beat_wait(beat_r, ilv, ext)) begin
          rdy = 1'b1;
          stop = cfg_r[`BDC_B_BW_DIS] && req_wr_r && req_burst_r && beat_r == 2'h0;
          // Refresh is not looked at until the burst is over
          last = beat_r == `BDC_LAST_BEAT || !s_blast_n || !req_burst_r || stop;
          wcnt_nxt = 2'h0;
          beat_nxt = beat_r + 2'h1;
          if (last) begin
            state_nxt = bdc_pkg::BDC_PRE;
          end
        end
      end
      bdc_pkg::BDC_PRE: begin
        if (wcnt_r == `BDC_PRE_LAST + {1'b0, ext}) begin
          state_nxt = bdc_pkg::BDC_IDLE;
        end
      end
      bdc_pkg::BDC_REF_NOTE: begin
        wcnt_nxt = 2'h0;
        ref_row_nxt = ref_row_r + 12'h001;
        state_nxt = bdc_pkg::BDC_REF_RAS;
      end
      bdc_pkg::BDC_REF_RAS: begin
        if (wcnt_r == `BDC_RAS_LAST + {1'b0, ext}) begin
          wcnt_nxt = 2'h0;
          state_nxt = bdc_pkg::BDC_PRE;
        end
      end
    endcase
  end

  // DRAM address split for the current beat
  logic [29:0] word, wl;
  logic [4:0]  ncol;
  logic [11:0] amask, col, row;
  logic [1:0]  bank;
  logic        leaf, col_ph, in_acc, rd_beat, wr_beat;
  always_comb begin
    word = beat_word(req_addr_r, beat_r);
    leaf = ilv && word[0];
    wl = ilv ? {1'b0, word[29:1]} : word;
    ncol = (size[2] ? `BDC_COL_X4 : `BDC_COL_X1) + {2'h0, size[1:0], 1'b0};
    amask = ~(`BDC_ADDR_ONES << ncol);
    col = wl[11:0] & amask;
    row = 12'(wl >> ncol) & amask;
    bank = size[2] ? 2'(wl >> {ncol, 1'b0}) : 2'h0;
    in_acc = state_r == bdc_pkg::BDC_ACC;
    col_ph = in_acc && (beat_r != 2'h0
             || wcnt_r >= {1'b0, cfg_r[`BDC_B_ROW_HOLD]} + 2'h1);
    rd_beat = col_ph && !req_wr_r;
    wr_beat = col_ph && req_wr_r;
  end

  // Pin drive, registered so every data pin comes from a flop
  logic [11:0] addr_a_nxt, addr_b_nxt;
  logic [3:0]  ras_a_nxt, ras_b_nxt, cas_a_nxt, cas_b_nxt, lanes;
  logic        rdy_r, btrm_nxt, refn_nxt, mwe_a_nxt, mwe_b_nxt, b1_nxt, b2_nxt, la_nxt,
               lb_nxt, nleaf, short_le;
  always_comb begin
    lanes = ~req_be_n_r;
    addr_a_nxt = col_ph ? col : row;
    ras_a_nxt = 4'hF;
    ras_b_nxt = 4'hF;
    if (state_r == bdc_pkg::BDC_REF_RAS) begin
      addr_a_nxt = ref_row_r;
      ras_a_nxt = 4'h0;
      ras_b_nxt = ilv ? 4'h0 : 4'hF;
    end else if (in_acc) begin
      ras_a_nxt[bank] = 1'b0;
      ras_b_nxt[bank] = !ilv;
    end
    addr_b_nxt = ilv ? addr_a_nxt : 12'h000;
    cas_a_nxt = (col_ph && !leaf) ? ~lanes : 4'hF;
    cas_b_nxt = (col_ph && leaf) ? ~lanes : 4'hF;
    mwe_a_nxt = !(wr_beat && !leaf);
    mwe_b_nxt = !(wr_beat && leaf);
    btrm_nxt = !stop;
    refn_nxt = state_r != bdc_pkg::BDC_REF_NOTE;
    nleaf = ilv && (req_addr_r[0] ^ beat_nxt[0]);
    short_le = cfg_r[`BDC_B_BUF_SHARED]; // Modes 2 and 3 open the latch only on the ready clock
    la_nxt = !(wr_beat && !leaf && (!short_le || rdy));
    lb_nxt = !(wr_beat && leaf && (!short_le || rdy));
    unique case (cfg_r[`BDC_F_BUFMODE])
      2'h0: begin
        b1_nxt = !(rd_beat && !leaf);
        b2_nxt = !(rd_beat && leaf);
      end
      2'h1: begin
        b1_nxt = !(in_acc && !leaf);
        b2_nxt = !(in_acc && leaf);
      end
      2'h2: begin
        b1_nxt = !rd_beat;
        b2_nxt = nleaf;
      end
      2'h3: begin
        b1_nxt = !in_acc;
        b2_nxt = nleaf;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= `BDC_CFG_RESET;
      {conf_r, ic_r, dc_r, pend_r, ref_pend_r, req_wr_r, req_burst_r, req_cfg_r} <= 8'h00;
      tmr_r <= bdc_pkg::BDC_TMR_OFF;
      state_r <= bdc_pkg::BDC_IDLE;
      req_addr_r <= 30'h0000_0000;
      req_be_n_r <= 4'hF;
      {beat_r, wcnt_r} <= 4'h0;
      {pre_r, rcnt_r} <= 10'h000;
      ref_row_r <= 12'h000;
      {dram_addr_a, dram_addr_b} <= 24'h00_0000;
      {ras_a_n, ras_b_n, cas_a_n, cas_b_n} <= 16'hFFFF;
      {rdy_r, burst_stop_request_n, refresh_n, mwe_a_n, mwe_b_n} <= 5'h0F;
      {leaf_a_output_drive_n, leaf_b_output_drive_n} <= 2'h3;
      {leaf_a_write_latch_n, leaf_b_write_latch_n} <= 2'h3;
    end else begin
      cfg_r <= cfg_nxt;
      {conf_r, ic_r, dc_r} <= {conf_nxt, ic_nxt, dc_nxt};
      {pend_r, ref_pend_r} <= {pend_nxt, ref_pend_nxt};
      {req_wr_r, req_burst_r, req_cfg_r} <= {req_wr_nxt, req_burst_nxt, req_cfg_nxt};
      tmr_r <= tmr_nxt;
      state_r <= state_nxt;
      req_addr_r <= req_addr_nxt;
      req_be_n_r <= req_be_n_nxt;
      {beat_r, wcnt_r} <= {beat_nxt, wcnt_nxt};
      {pre_r, rcnt_r} <= {pre_nxt, rcnt_nxt};
      ref_row_r <= ref_row_nxt;
      {dram_addr_a, dram_addr_b} <= {addr_a_nxt, addr_b_nxt};
      {ras_a_n, ras_b_n, cas_a_n, cas_b_n} <= {ras_a_nxt, ras_b_nxt, cas_a_nxt, cas_b_nxt};
      {rdy_r, burst_stop_request_n, refresh_n} <= {rdy, btrm_nxt, refn_nxt};
      {mwe_a_n, mwe_b_n} <= {mwe_a_nxt, mwe_b_nxt};
      {leaf_a_output_drive_n, leaf_b_output_drive_n} <= {b1_nxt, b2_nxt};
      {leaf_a_write_latch_n, leaf_b_write_latch_n} <= {la_nxt, lb_nxt};
    end
  end

  // Either the controller or a bus watch timeout may end the data phase
  assign ready_n = !(rdy_r || wd_ready);
  assign open_row_cache_inst = ic_r;
  assign open_row_cache_data = dc_r;

  bdc_timer u_timer (
    .clk    (clk),
    .rst    (rst),
    .reload (cfg_r[`BDC_F_RELOAD]),
    .mode   (tmr_r),
    .ack    (tmr_ack),
    .irq_n  (timer_irq_n)
  );

  bdc_bus_watch u_watch (
    .clk       (clk),
    .rst       (rst),
    .den_act   (!s_den_n),
    .timeout   (cfg_r[`BDC_F_TIMEOUT]),
    .rdy_en    (cfg_r[`BDC_B_WD_RDY_EN]),
    .flt_en    (cfg_r[`BDC_B_FLT_EN]),
    .flt_level (cfg_r[`BDC_B_FLT_LEVEL]),
    .rd_clear  (rd_watch),
    .wd_ready  (wd_ready),
    .fault_n   (bus_fault_out_n)
  );
endmodule
`default_nettype wire

// ---- inc/bdc_defines.svh ----
`ifndef BDC_DEFINES_SVH
`define BDC_DEFINES_SVH

// Configuration word field positions
`define BDC_F_RSVD       1:0
`define BDC_F_OPCTL      5:2
`define BDC_F_REF_LO     7:6
`define BDC_F_REF_HI     11:8
`define BDC_F_SIZE       14:12
`define BDC_F_BUFMODE    16:15
`define BDC_B_BUF_SHARED 16
`define BDC_B_ILV_DIS    17
`define BDC_B_ROW_HOLD   18
`define BDC_B_BW_DIS     19
`define BDC_B_CYC_EXT    20
`define BDC_F_BLOCK      31:21
`define BDC_F_RELOAD     55:32
`define BDC_F_TIMEOUT    60:56
`define BDC_B_FLT_LEVEL  61
`define BDC_B_FLT_EN     62
`define BDC_B_WD_RDY_EN  63
`define BDC_CFG_RESET    64'h0000_0000_0000_0000

// Configuration access decode on the word address (A31..A2)
`define BDC_A_SPACE      29:14
`define BDC_A_ID         13:11
`define BDC_A_BYTE       10:8
`define BDC_A_DATA       7:0
`define BDC_A_BLOCK      29:19
`define BDC_CFG_SPACE    16'hFF0F
`define BDC_BYTE_OPCTL   3'h0
`define BDC_BYTE_WATCH   3'h7

// Operation control codes, byte 0 bits 5..2
`define BDC_OP_NONE      4'h0
`define BDC_OP_IC_DIS    4'h4
`define BDC_OP_IC_EN     4'h6
`define BDC_OP_DC_DIS    4'h5
`define BDC_OP_DC_EN     4'h7
`define BDC_OP_TMR_ACK   4'h8
`define BDC_OP_TMR_LVL   4'hA
`define BDC_OP_TMR_OFF   4'hC
`define BDC_OP_TMR_EDGE  4'hE

// Timing counts in clocks
`define BDC_WAIT_FIRST   2'h2
`define BDC_WAIT_NIL     2'h1
`define BDC_WAIT_ILV_EXT 2'h1
`define BDC_RAS_LAST     2'h2
`define BDC_PRE_LAST     2'h1
`define BDC_LAST_BEAT    2'h3
`define BDC_REF_PRE_LAST 4'hF
`define BDC_PULSE_CLKS   2'h2
`define BDC_COL_X1       5'h09
`define BDC_COL_X4       5'h08
`define BDC_BLOCK_ONES   11'h7FF
`define BDC_ADDR_ONES    12'hFFF

`endif

// ---- inc/bdc_pkg.sv ----
`default_nettype none
package bdc_pkg;
  typedef enum logic [1:0] {BDC_TMR_OFF, BDC_TMR_LEVEL, BDC_TMR_EDGE} bdc_tmr_mode_t;
  typedef enum logic [2:0] {BDC_IDLE, BDC_CFG, BDC_ACC, BDC_PRE, BDC_REF_NOTE,
                            BDC_REF_RAS} bdc_state_t;
endpackage
`default_nettype wire

// ---- tb/bdc_chk.sv ----
`default_nettype none
module bdc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ready_n,
  input wire logic       burst_stop_request_n,
  input wire logic       bus_fault_out_n,
  input wire logic       timer_irq_n,
  input wire logic       refresh_n,
  input wire logic [3:0] ras_a_n,
  input wire logic [3:0] cas_a_n,
  input wire logic       data_phase_active_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Stop request rides on one ready only
  stop_rdy_a: assert property (!burst_stop_request_n |-> !ready_n)
    else $error("stop without ready");
  stop_one_a: assert property (!burst_stop_request_n |=> burst_stop_request_n)
    else $error("stop too long");
  // Notice lasts one cycle, then every leaf A bank strobes its row
  ref_ras_a: assert property (!refresh_n |=> refresh_n && ras_a_n == 4'h0)
    else $error("refresh strobe missing");
  row_col_a: assert property (cas_a_n != 4'hF |-> ras_a_n != 4'hF)
    else $error("column strobe without row");
  irq_two_a: assert property ($fell(timer_irq_n) |=> !timer_irq_n)
    else $error("timer pulse short");
  flt_two_a: assert property ($fell(bus_fault_out_n) |=> !bus_fault_out_n)
    else $error("fault pulse short");
  flt_den_a: assert property (
    $fell(bus_fault_out_n) |-> !$past(data_phase_active_in_n)) else $error("fault without den");
  rst_idle_a: assert property (
    $fell(rst) |-> ready_n && timer_irq_n && bus_fault_out_n) else $error("busy after reset");
  cover property (!burst_stop_request_n);
  cover property (!refresh_n);
  cover property ($fell(timer_irq_n));
endmodule
bind bdc_top bdc_chk u_chk (
  .clk(clk), .rst(rst), .ready_n(ready_n), .burst_stop_request_n(burst_stop_request_n),
  .bus_fault_out_n(bus_fault_out_n), .timer_irq_n(timer_irq_n), .refresh_n(refresh_n),
  .ras_a_n(ras_a_n), .cas_a_n(cas_a_n), .data_phase_active_in_n(data_phase_active_in_n));
`default_nettype wire

// ---- tb/bdc_cpu.sv ----
`default_nettype none
module bdc_cpu (
  input  wire logic        clk,
  input  wire logic        ready_n,
  input  wire logic        burst_stop_request_n,
  output logic      [29:0] proc_addr,
  output logic             proc_ads_n,
  output logic             proc_blast_n,
  output logic             proc_w_r
);
  timeunit 1ns;
  timeprecision 1ps;
  int t[4];
  int n;
  int s;
  int cyc = 0;
  // Cycle stamp for strobes and answers
  always @(posedge clk) cyc <= cyc + 1;
  initial begin
    proc_addr = 30'h0000_0000;
    proc_ads_n = 1'b1;
    proc_blast_n = 1'b1;
    proc_w_r = 1'b0;
  end
  // One access; a cut burst finishes as single cycles, so no beat is lost
  task automatic xfer(input logic [29:0] a, input logic w, input int nb);
    int k;
    int left;
    int want;
    logic one;
    n = 0;
    left = nb;
    one = (nb == 1);
    while (left > 0) begin
      @(negedge clk);
      proc_addr = a + 30'(nb - left);
      proc_w_r = w;
      proc_blast_n = ~one;
      proc_ads_n = 1'b0;
      @(posedge clk);
      s = cyc;
      @(negedge clk);
      proc_ads_n = 1'b1;
      want = one ? 1 : left;
      for (k = 0; k < 40 && want > 0; k++) begin
        @(posedge clk);
        if (ready_n === 1'b0) begin
          t[n] = cyc;
          n++;
          left--;
          want--;
          if (burst_stop_request_n === 1'b0) begin
            one = 1'b1;
            want = 0;
          end
        end
      end
      if (want > 0)
        left = 0;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [29:0] base = 30'h0020_0000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        den_n = 1'b1;
  logic [29:0] addr;
  logic        ads_n, blst_n, w_r, rdy_n, bst_n, flt_n, irq_n, ref_n, c_i, c_d;
  logic [3:0]  rb_n;
  logic [23:0] rows [4] = '{24'h80_2000, 24'h90_3010, 24'h82_2111, 24'h92_3222};
  logic [5:0]  ops [4] = '{6'h1A, 6'h1F, 6'h11, 6'h14};
  int          err_count = 0, n_compared = 0, rc = 0, bs = 0, lt, m, g;
  bit          b_used;
  always #2.5 clk = ~clk;
  // Tallies read back by the scenarios
  always @(posedge clk) begin
    rc += (rdy_n === 1'b0);
    bs += (bst_n === 1'b0);
    b_used |= (rb_n !== 4'hF);
  end
  bdc_top dut (
    .clk(clk), .rst(rst), .proc_addr(addr), .proc_ads_n(ads_n), .proc_blast_n(blst_n),
    .proc_w_r(w_r), .proc_be_n(4'h0), .proc_d_c(1'b1), .proc_sup_n(1'b0),
    .data_phase_active_in_n(den_n), .chip_id(3'h5), .ready_n(rdy_n),
    .burst_stop_request_n(bst_n), .bus_fault_out_n(flt_n), .timer_irq_n(irq_n),
    .refresh_n(ref_n), .dram_addr_a(), .dram_addr_b(), .ras_a_n(), .ras_b_n(rb_n),
    .cas_a_n(), .cas_b_n(), .mwe_a_n(), .mwe_b_n(), .leaf_a_output_drive_n(),
    .leaf_b_output_drive_n(), .leaf_a_write_latch_n(), .leaf_b_write_latch_n(),
    .open_row_cache_inst(c_i), .open_row_cache_data(c_d));
  bdc_cpu cpu (
    .clk(clk), .ready_n(rdy_n), .burst_stop_request_n(bst_n), .proc_addr(addr),
    .proc_ads_n(ads_n), .proc_blast_n(blst_n), .proc_w_r(w_r));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic [29:0] a, input logic w, input int nb);
    cpu.xfer(a, w, nb);
    check(cpu.n, nb);
    if (cpu.n != nb)
      final_report();
    @(negedge clk);
  endtask
  task automatic cfg(input logic [2:0] b, input logic [7:0] d, input logic w = 1'b1);
    acc({16'hFF0F, 3'h5, b, d}, w, 1);
  endtask
  function automatic logic sg(input bit f);
    return f ? irq_n : flt_n;
  endfunction
  // Length of the next low run, capped at 60; zero when none comes
  task automatic low_run(input bit f, output int r);
    int k;
    for (k = 0; k < 300 && sg(f) !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 300 && sg(f) !== 1'b0; k++) @(posedge clk);
    lt = cpu.cyc;
    for (r = 0; r < 60 && sg(f) === 1'b0; r++) @(posedge clk);
  endtask
  // Refresh interval, taken between later notices so a rate change has settled
  task automatic ref_gap(output int r);
    int k, a, f;
    f = 0;
    for (k = 0; k < 3500 && f < 3; k++) begin
      @(posedge clk);
      if (ref_n === 1'b0) begin
        f++;
        if (f == 2) a = k;
      end
    end
    r = k - 1 - a;
  endtask
  // Start just after a refresh so none lands inside the access
  task automatic quiet();
    int k;
    for (k = 0; k < 1100 && ref_n !== 1'b0; k++) @(posedge clk);
    check(ref_n, 1'b0);
    repeat (12) @(negedge clk);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    cfg(3'h3, 8'h00);
    cfg(3'h1, 8'h1F);
    cfg(3'h0, 8'hC0);
    foreach (rows[i]) begin
      cfg(3'h2, rows[i][23:16]);
      quiet();
      b_used = 1'b0;
      acc(base, 1'b0, 4);
      g = cpu.t[0] - cpu.s - rows[i][15:12];
      // Two sync flops, capture, start and output flop lie before the waits
      check(g, 5);
      for (int r = 1; r < 4; r++)
        check(cpu.t[r] - cpu.t[r-1] - 1, rows[i][15-4*r -: 4]);
      check(b_used, !rows[i][17]);
    end
    $display("done: burst table");
    foreach (ops[i]) begin
      cfg(3'h0, {2'b00, ops[i][5:2], 2'b00});
      repeat (2) @(negedge clk);
      check({c_i, c_d}, ops[i][1:0]);
    end
    $display("done: cache ops");
    cfg(3'h2, 8'h88);
    quiet();
    g = bs;
    acc(base + 30'h0000_0004, 1'b1, 4);
    check(bs - g, 1);
    cpu.xfer(30'h0040_0000, 1'b0, 1);
    check(cpu.n, 0);
    acc(30'h003F_FFFF, 1'b0, 1);
    $display("done: stop and decode");
    cfg(3'h1, 8'h10);
    ref_gap(g);
    check(g, 64);
    cfg(3'h0, 8'h30);
    ref_gap(g);
    check(g, 64);
    cfg(3'h0, 8'h00);
    ref_gap(g);
    check(g, 16);
    $display("done: refresh");
    cfg(3'h7, 8'hC4);
    g = rc;
    den_n = 1'b0;
    low_run(1'b0, m);
    check(m, 2);
    @(negedge clk);
    den_n = 1'b1;
    check(rc - g, 1);
    cfg(3'h7, 8'hE4);
    den_n = 1'b0;
    low_run(1'b0, m);
    check(m, 60);
    @(negedge clk);
    den_n = 1'b1;
    cfg(3'h7, 8'h00, 1'b0);
    repeat (2) @(negedge clk);
    check(flt_n, 1'b1);
    $display("done: bus watch");
    cfg(3'h4, 8'h40);
    cfg(3'h5, 8'h00);
    cfg(3'h6, 8'h00);
    cfg(3'h0, 8'h38);
    low_run(1'b1, m);
    check(m, 2);
    g = lt;
    low_run(1'b1, m);
    check(lt - g, 65);
    cfg(3'h0, 8'h28);
    low_run(1'b1, m);
    check(m, 60);
    cfg(3'h0, 8'h20);
    check(irq_n, 1'b1);
    low_run(1'b1, m);
    check(m, 60);
    $display("done: timer");
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check({rdy_n, bst_n, flt_n, irq_n, ref_n}, 5'h1F);
    low_run(1'b1, m);
    check(m, 0);
    cpu.xfer(base, 1'b0, 1);
    check(cpu.n, 0);
    $display("done: reset");
    final_report();
  end
endmodule
`default_nettype wire
